/* design/ahb_reg_slave.sv */
// ahb-lite slave that turns word transfers into controller register accesses
// assumes hsel is decoded outside and only single word transfers are issued
`default_nettype none
module ahb_reg_slave (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave side
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// controller register paths
	reg_if.bus a_regs,
	reg_if.bus b_regs
);
	typedef enum logic [1:0] {
		st_idle = 2'b00,
		st_access = 2'b01,
		st_done = 2'b10
	} slave_state_t;

	slave_state_t state;
	slave_state_t next_state;
	logic [8:0] addr_q;
	logic write_q;
	logic word_q;
	logic capture;

	// a transfer is taken only when the previous one has finished
	assign capture = hsel & hready & htrans[1];

	// one wait state lets hrdata come straight from a flip-flop
	always_comb begin
		next_state = st_idle;
		case (state)
			st_idle: next_state = capture ? st_access : st_idle;
			st_access: next_state = st_done;
			st_done: next_state = capture ? st_access : st_idle;
			default: next_state = st_idle;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= st_idle;
		end else begin
			state <= next_state;
		end
	end

	// address phase capture
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			addr_q <= 9'h000;
			write_q <= 1'b0;
			word_q <= 1'b0;
		end else if (capture) begin
			addr_q <= haddr[8:0];
			write_q <= hwrite;
			word_q <= (hsize == 3'b010) && (haddr[1:0] == 2'b00); // other sizes are ignored
		end
	end

	// strobes toward the controllers, valid in the first data-phase cycle
	assign a_regs.wr = (state == st_access) & write_q & word_q & ~addr_q[pin_mux_pkg::CTRL_SEL_BIT];
	assign b_regs.wr = (state == st_access) & write_q & word_q & addr_q[pin_mux_pkg::CTRL_SEL_BIT];
	assign a_regs.offset = addr_q[7:0];
	assign b_regs.offset = addr_q[7:0];
	assign a_regs.wdata = hwdata;
	assign b_regs.wdata = hwdata;

	// read data latched at the end of the wait state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= pin_mux_pkg::RST_ZERO;
		end else if (state == st_access) begin
			if (write_q || !word_q) begin
				hrdata <= pin_mux_pkg::RST_ZERO;
			end else if (addr_q[pin_mux_pkg::CTRL_SEL_BIT]) begin
				hrdata <= b_regs.rdata;
			end else begin
				hrdata <= a_regs.rdata;
			end
		end
	end

	assign hreadyout = (state != st_access);
	assign hresp = 1'b0; // always okay
endmodule // ahb_reg_slave
`default_nettype wire

/* design/line_ctrl.sv */
// register set of one parallel line controller
// assumes register strobes from the bus slave and synchronised pin levels
`default_nettype none
module line_ctrl #(
	parameter logic [31:0] IMPL = 32'h0000_0000,
	parameter logic [31:0] PERIPH = 32'h0000_0000
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// register path
	reg_if.ctrl regs,
	// synchronised pin levels
	input wire logic [31:0] pin_level,
	// line state toward the pin logic
	output logic [31:0] gpio_own,
	output logic [31:0] out_en,
	output logic [31:0] out_data,
	output logic [31:0] open_drain
);
	logic wr_own_set;
	logic wr_own_clr;

	assign wr_own_set = regs.wr && (regs.offset == pin_mux_pkg::OFF_OWN_SET);
	assign wr_own_clr = regs.wr && (regs.offset == pin_mux_pkg::OFF_OWN_CLEAR);

	// ownership: only lines with a peripheral can be handed over
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			gpio_own <= IMPL;
		end else begin
			gpio_own <= pin_mux_pkg::set_clear(gpio_own, regs.wdata, wr_own_set, wr_own_clr, PERIPH);
		end
	end

	// open-drain option
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			open_drain <= pin_mux_pkg::RST_OD;
		end else begin
			open_drain <= pin_mux_pkg::set_clear(open_drain, regs.wdata,
				regs.wr && (regs.offset == pin_mux_pkg::OFF_OD_SET),
				regs.wr && (regs.offset == pin_mux_pkg::OFF_OD_CLEAR), IMPL);
		end
	end

	// output enable, stored even while a peripheral owns the line
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			out_en <= pin_mux_pkg::RST_OUT_EN;
		end else begin
			out_en <= pin_mux_pkg::set_clear(out_en, regs.wdata,
				regs.wr && (regs.offset == pin_mux_pkg::OFF_OUT_EN_SET),
				regs.wr && (regs.offset == pin_mux_pkg::OFF_OUT_EN_CLEAR), IMPL);
		end
	end

	// output data level
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			out_data <= pin_mux_pkg::RST_DATA;
		end else begin
			out_data <= pin_mux_pkg::set_clear(out_data, regs.wdata,
				regs.wr && (regs.offset == pin_mux_pkg::OFF_DATA_SET),
				regs.wr && (regs.offset == pin_mux_pkg::OFF_DATA_CLEAR), IMPL);
		end
	end

	// read mux; every bit outside the implemented lines reads zero
	always_comb begin
		case (regs.offset)
			pin_mux_pkg::OFF_OWN_STATUS: regs.rdata = gpio_own & IMPL;
			pin_mux_pkg::OFF_OUT_EN_STATUS: regs.rdata = out_en & IMPL;
			pin_mux_pkg::OFF_DATA_STATUS: regs.rdata = out_data & IMPL;
			pin_mux_pkg::OFF_PIN_STATUS: regs.rdata = pin_level & IMPL;
			pin_mux_pkg::OFF_OD_STATUS: regs.rdata = open_drain & IMPL;
			default: regs.rdata = pin_mux_pkg::RST_ZERO;
		endcase
	end
endmodule // line_ctrl
`default_nettype wire

/* design/pin_mux.sv */
// open-drain option and pin-to-peripheral routing of two line controllers
// assumes ahb-lite access with hsel decoded outside; pins are split into in/out/enable
//
// Behaviour
// - with open drain on, a line only pulls low and otherwise releases
// - open drain set register bits enable, clear register bits disable, zeros ignored
// - open drain applies to gpio-owned and peripheral-owned lines alike
// - open drain status reads one per line configured for shared driving
// - same bit per line in all registers; a has 30 lines, b has 28
// - after reset every line is gpio owned and an input
// - a bits 0-8 timers 3-5, bits 9-13 external and fast interrupts
// - a bits 14-22 three serial ports as clock, transmit, receive
// - a bits 23-29 synchronous serial clock, data, four chip selects
// - b bits 0-2 multiprocessor port strobes, bits 3-16 plain gpio
// - b bit 17 clock out, 18 boot select, 19-27 timers 0-2
// - gpio-owned multiplexed line gives its peripheral input a zero
// - lines without a peripheral ignore ownership writes and read owned
// - unimplemented bits ignore writes and read zero
// - ownership status reads one for gpio, zero for peripheral; set/clear change it
//
// The AHB-Lite interface to the registers and the register offsets are this design's own decisions.
`default_nettype none
module pin_mux (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// controller a pins
	input wire logic [29:0] a_pin_in,
	output logic [29:0] a_pin_out,
	output logic [29:0] a_pin_oe,
	// controller a peripheral side, one bit per line
	input wire logic [29:0] a_periph_out,
	input wire logic [29:0] a_periph_oe,
	output logic [29:0] a_periph_in,
	// controller b pins
	input wire logic [27:0] b_pin_in,
	output logic [27:0] b_pin_out,
	output logic [27:0] b_pin_oe,
	// controller b peripheral side, one bit per line
	input wire logic [27:0] b_periph_out,
	input wire logic [27:0] b_periph_oe,
	output logic [27:0] b_periph_in
);
	reg_if a_regs ();
	reg_if b_regs ();

	logic [29:0] a_sync1;
	logic [29:0] a_sync2;
	logic [27:0] b_sync1;
	logic [27:0] b_sync2;
	logic [31:0] a_level;
	logic [31:0] b_level;
	logic [31:0] a_own;
	logic [31:0] a_oe;
	logic [31:0] a_data;
	logic [31:0] a_od;
	logic [31:0] b_own;
	logic [31:0] b_oe;
	logic [31:0] b_data;
	logic [31:0] b_od;
	logic [31:0] a_mux_oe;
	logic [31:0] a_mux_data;
	logic [31:0] b_mux_oe;
	logic [31:0] b_mux_data;
	logic [31:0] next_a_pad_oe;
	logic [31:0] next_a_pad_out;
	logic [31:0] next_b_pad_oe;
	logic [31:0] next_b_pad_out;

	// bus slave and the two register sets
	ahb_reg_slave slave (
		.hclk(hclk),
		.hresetn(hresetn),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hwdata(hwdata),
		.hready(hready),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.hrdata(hrdata),
		.a_regs(a_regs),
		.b_regs(b_regs)
	);

	line_ctrl #(
		.IMPL(pin_mux_pkg::A_IMPL),
		.PERIPH(pin_mux_pkg::A_PERIPH)
	) port_ctrl_a (
		.hclk(hclk),
		.hresetn(hresetn),
		.regs(a_regs),
		.pin_level(a_level),
		.gpio_own(a_own),
		.out_en(a_oe),
		.out_data(a_data),
		.open_drain(a_od)
	);

	line_ctrl #(
		.IMPL(pin_mux_pkg::B_IMPL),
		.PERIPH(pin_mux_pkg::B_PERIPH)
	) port_ctrl_b (
		.hclk(hclk),
		.hresetn(hresetn),
		.regs(b_regs),
		.pin_level(b_level),
		.gpio_own(b_own),
		.out_en(b_oe),
		.out_data(b_data),
		.open_drain(b_od)
	);

	// pins are asynchronous to hclk, so two flops before any reader
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			a_sync1 <= 30'h0000_0000;
			a_sync2 <= 30'h0000_0000;
			b_sync1 <= 28'h000_0000;
			b_sync2 <= 28'h000_0000;
		end else begin
			a_sync1 <= a_pin_in;
			a_sync2 <= a_sync1;
			b_sync1 <= b_pin_in;
			b_sync2 <= b_sync1;
		end
	end

	assign a_level = {2'b00, a_sync2};
	assign b_level = {4'h0, b_sync2};

	// owner select: gpio state or the peripheral, whose drive is limited to its own direction
	assign a_mux_oe = (a_own & a_oe) | (~a_own & {2'b00, a_periph_oe} & pin_mux_pkg::A_DRIVE);
	assign a_mux_data = (a_own & a_data) | (~a_own & {2'b00, a_periph_out});
	assign b_mux_oe = (b_own & b_oe) | (~b_own & {4'h0, b_periph_oe} & pin_mux_pkg::B_DRIVE);
	assign b_mux_data = (b_own & b_data) | (~b_own & {4'h0, b_periph_out});

	// open drain is applied after the owner select, so it covers both owners
	assign next_a_pad_oe = pin_mux_pkg::pad_enable(a_mux_oe, a_mux_data, a_od) & pin_mux_pkg::A_IMPL;
	assign next_a_pad_out = pin_mux_pkg::pad_level(a_mux_data, a_od) & pin_mux_pkg::A_IMPL;
	assign next_b_pad_oe = pin_mux_pkg::pad_enable(b_mux_oe, b_mux_data, b_od) & pin_mux_pkg::B_IMPL;
	assign next_b_pad_out = pin_mux_pkg::pad_level(b_mux_data, b_od) & pin_mux_pkg::B_IMPL;

	// pad drivers registered; costs one cycle but keeps the pads glitch free
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			a_pin_oe <= 30'h0000_0000;
			a_pin_out <= 30'h0000_0000;
			b_pin_oe <= 28'h000_0000;
			b_pin_out <= 28'h000_0000;
		end else begin
			a_pin_oe <= next_a_pad_oe[29:0];
			a_pin_out <= next_a_pad_out[29:0];
			b_pin_oe <= next_b_pad_oe[27:0];
			b_pin_out <= next_b_pad_out[27:0];
		end
	end

	// peripheral inputs see the pin only when the peripheral owns the line
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			a_periph_in <= 30'h0000_0000;
			b_periph_in <= 28'h000_0000;
		end else begin
			a_periph_in <= a_sync2 & ~a_own[29:0] & pin_mux_pkg::A_RECV[29:0];
			b_periph_in <= b_sync2 & ~b_own[27:0] & pin_mux_pkg::B_RECV[27:0];
		end
	end
endmodule // pin_mux
`default_nettype wire

/* design/pin_mux_pkg.sv */
// constants and helpers shared by the open-drain pin multiplexer
// assumes a 32-bit register window where address bit 8 picks controller b
`default_nettype none
package pin_mux_pkg;
	// line counts of the two controllers
	localparam int unsigned A_LINES = 30;
	localparam int unsigned B_LINES = 28;
	// address bit that selects controller b inside the window
	localparam int unsigned CTRL_SEL_BIT = 8;
	// register offsets inside one controller
	localparam logic [7:0] OFF_OWN_SET = 8'h00;
	localparam logic [7:0] OFF_OWN_CLEAR = 8'h04;
	localparam logic [7:0] OFF_OWN_STATUS = 8'h08;
	localparam logic [7:0] OFF_OUT_EN_SET = 8'h10;
	localparam logic [7:0] OFF_OUT_EN_CLEAR = 8'h14;
	localparam logic [7:0] OFF_OUT_EN_STATUS = 8'h18;
	localparam logic [7:0] OFF_DATA_SET = 8'h30;
	localparam logic [7:0] OFF_DATA_CLEAR = 8'h34;
	localparam logic [7:0] OFF_DATA_STATUS = 8'h38;
	localparam logic [7:0] OFF_PIN_STATUS = 8'h3C;
	localparam logic [7:0] OFF_OD_SET = 8'h50;
	localparam logic [7:0] OFF_OD_CLEAR = 8'h54;
	localparam logic [7:0] OFF_OD_STATUS = 8'h58;
	// implemented lines
	localparam logic [31:0] A_IMPL = 32'h3FFF_FFFF;
	localparam logic [31:0] B_IMPL = 32'h0FFF_FFFF;
	// lines that have a peripheral signal
	localparam logic [31:0] A_PERIPH = 32'h3FFF_FFFF;
	localparam logic [31:0] B_PERIPH = 32'h0FFE_0007;
	// peripheral signals that may drive the pin (output or two-way)
	localparam logic [31:0] A_DRIVE = 32'h3FB6_C1B6;
	localparam logic [31:0] B_DRIVE = 32'h0DB2_0000;
	// peripheral signals that receive from the pin (input or two-way)
	localparam logic [31:0] A_RECV = 32'h07DB_7FFF;
	localparam logic [31:0] B_RECV = 32'h0FFC_0007;
	// values after reset
	localparam logic [31:0] RST_OD = 32'h0000_0000;
	localparam logic [31:0] RST_OUT_EN = 32'h0000_0000;
	localparam logic [31:0] RST_DATA = 32'h0000_0000;
	localparam logic [31:0] RST_ZERO = 32'h0000_0000;

	// set/clear update of a status vector; on set and clear together, clear wins and the set is dropped
	function automatic logic [31:0] set_clear(input logic [31:0] cur, input logic [31:0] bits,
		input logic do_set, input logic do_clr, input logic [31:0] mask);
		set_clear = cur;
		if (do_set) begin
			set_clear = cur | (bits & mask);
		end
		if (do_clr) begin
			set_clear = cur & ~(bits & mask);
		end
	endfunction

	// pad enable: an open-drain line only drives while the data is low
	function automatic logic [31:0] pad_enable(input logic [31:0] oe, input logic [31:0] data,
		input logic [31:0] od);
		pad_enable = oe & ~(od & data);
	endfunction

	// pad level: an open-drain line never drives high
	function automatic logic [31:0] pad_level(input logic [31:0] data, input logic [31:0] od);
		pad_level = data & ~od;
	endfunction
endpackage
`default_nettype wire

/* design/reg_if.sv */
// register access path from the bus slave to one line controller
// assumes one bus-side driver and one controller per instance
`default_nettype none
interface reg_if;
	logic wr;
	logic [7:0] offset;
	logic [31:0] wdata;
	logic [31:0] rdata;
	modport bus (output wr, output offset, output wdata, input rdata);
	modport ctrl (input wr, input offset, input wdata, output rdata);
endinterface
`default_nettype wire

/* testbench/pad_model.sv */
// pads of one controller: pull-up plus outside open-collector drivers
// assumes the bench chooses which lines the outside pulls low
`default_nettype none
module pad_model #(
	parameter int W = 30
) (
	// device side
	input wire logic [W-1:0] pin_out,
	input wire logic [W-1:0] pin_oe,
	// outside drivers
	input wire logic [W-1:0] ext_low,
	// level seen by the device
	output logic [W-1:0] pin_in
);
	timeunit 1ns;
	timeprecision 1ps;
	// wired-and: a released line floats up, any low driver wins
	assign pin_in = ~ext_low & (~pin_oe | pin_out);
endmodule // pad_model
`default_nettype wire

/* testbench/pin_mux_assertions.sv */
// checker for the bus answer and the peripheral-side inputs of pin_mux
// assumes it is bound to pin_mux and sees only its ports
`default_nettype none
module pin_mux_assertions (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// bus side
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	// line side
	input wire logic [29:0] a_pin_in,
	input wire logic [29:0] a_pin_oe,
	input wire logic [29:0] a_periph_in,
	input wire logic [27:0] b_pin_oe,
	input wire logic [27:0] b_periph_in
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// bus answer: one wait state, okay only, stable read data between transfers
	a_one_wait: assert property (hsel && hready && htrans[1] |=> !hreadyout ##1 hreadyout)
		else $error("transfer did not take exactly one wait state");
	a_resp_okay: assert property (hresp == 1'b0)
		else $error("error response seen");
	a_rdata_hold: assert property (hreadyout && !(hsel && htrans[1]) |=> $stable(hrdata))
		else $error("read data moved without a transfer");
	a_top_bits_zero: assert property (hreadyout |-> hrdata[31:30] == 2'b00)
		else $error("unimplemented bits read as one");
	// peripheral inputs: output-only and plain lines never receive
	a_a_out_only: assert property ((a_periph_in & 30'h3824_8000) == 30'h0)
		else $error("output-only peripheral on a sees a level");
	a_b_no_recv: assert property ((b_periph_in & 28'h003_FFF8) == 28'h0)
		else $error("line of b without input sees a level");
	// a receive input only reports a pad level that was high three edges earlier
	a_rx_latency: assert property (a_periph_in[16] |-> $past(a_pin_in[16], 3))
		else $error("receive input high without a high pad");
	// no line is driven when reset lets go
	a_reset_input: assert property ($rose(hresetn) |-> a_pin_oe == 30'h0 && b_pin_oe == 28'h0)
		else $error("line driven after reset");
endmodule // pin_mux_assertions

bind pin_mux pin_mux_assertions u_pin_mux_assertions (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
	.htrans(htrans), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
	.a_pin_in(a_pin_in), .a_pin_oe(a_pin_oe), .a_periph_in(a_periph_in), .b_pin_oe(b_pin_oe),
	.b_periph_in(b_periph_in));
`default_nettype wire

/* testbench/tb.sv */
// self-checking bench for the open-drain pin multiplexer
// assumes one ahb-lite master and pull-ups on every pad
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata;
	logic [29:0] a_pin_in, a_pin_out, a_pin_oe, a_periph_out, a_periph_oe, a_periph_in, a_ext;
	logic [27:0] b_pin_in, b_pin_out, b_pin_oe, b_periph_out, b_periph_oe, b_periph_in, b_ext;
	int n_mismatch = 0;
	int samples_checked = 0;

	pin_mux u_pin_mux (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .a_pin_in(a_pin_in), .a_pin_out(a_pin_out), .a_pin_oe(a_pin_oe),
		.a_periph_out(a_periph_out), .a_periph_oe(a_periph_oe), .a_periph_in(a_periph_in),
		.b_pin_in(b_pin_in), .b_pin_out(b_pin_out), .b_pin_oe(b_pin_oe), .b_periph_out(b_periph_out),
		.b_periph_oe(b_periph_oe), .b_periph_in(b_periph_in));
	pad_model #(.W(30)) u_pad_model_a (.pin_out(a_pin_out), .pin_oe(a_pin_oe), .ext_low(a_ext), .pin_in(a_pin_in));
	pad_model #(.W(28)) u_pad_model_b (.pin_out(b_pin_out), .pin_oe(b_pin_oe), .ext_low(b_ext), .pin_in(b_pin_in));

	// 100 mhz clock
	always #5 hclk = ~hclk;

	// a hung bus must still reach the verdict
	initial begin
		repeat (20000) @(posedge hclk);
		n_mismatch++;
		conclude();
	end

	task automatic conclude();
		$display("checked %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// byte address of one register of controller c; only bit 0 of c picks the controller
	function automatic logic [31:0] ad(input int c, input logic [7:0] o);
		ad = {23'h0, c[0], o};
	endfunction

	// implemented lines of controller c
	function automatic logic [31:0] impl(input int c);
		impl = c[0] ? 32'h0FFF_FFFF : 32'h3FFF_FFFF;
	endfunction

	// one single word transfer; starts at the next rising edge, each phase held until hready
	task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
		int n;
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= w;
		n = 0;
		do begin
			@(negedge hclk);
			n++;
		end while (!hreadyout && n < 64);
		// a slave that never answers ends the run here
		if (!hreadyout) begin
			n_mismatch++;
			conclude();
		end
		@(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		n = 0;
		do begin
			@(negedge hclk);
			r = hrdata;
			n++;
		end while (!hreadyout && n < 64);
		if (!hreadyout) begin
			n_mismatch++;
			conclude();
		end
		@(posedge hclk);
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(a, 1'b1, d, r);
	endtask

	task automatic rd(input logic [31:0] a, input logic [31:0] exp);
		logic [31:0] r;
		bus(a, 1'b0, 32'h0000_0000, r);
		chk(r, exp);
	endtask

	// lets pads and synchronisers follow, then steps off the edge
	task automatic settle(input int n);
		repeat (n) @(posedge hclk);
		#1;
	endtask

	task automatic s_reset();
		for (int c = 0; c < 2; c++) begin
			rd(ad(c, pin_mux_pkg::OFF_OWN_STATUS), impl(c));
			rd(ad(c, pin_mux_pkg::OFF_OD_STATUS), 32'h0000_0000);
			rd(ad(c, pin_mux_pkg::OFF_OUT_EN_STATUS), 32'h0000_0000);
		end
	endtask

	task automatic s_od_regs();
		for (int c = 0; c < 2; c++) begin
			wr(ad(c, pin_mux_pkg::OFF_OD_SET), 32'hFFFF_FFFF);
			rd(ad(c, pin_mux_pkg::OFF_OD_STATUS), impl(c));
			wr(ad(c, pin_mux_pkg::OFF_OD_CLEAR), 32'h8000_0005);
			rd(ad(c, pin_mux_pkg::OFF_OD_STATUS), impl(c) & 32'hFFFF_FFFA);
			wr(ad(c, pin_mux_pkg::OFF_OD_SET), 32'h0000_0001);
			rd(ad(c, pin_mux_pkg::OFF_OD_STATUS), impl(c) & 32'hFFFF_FFFB);
			wr(ad(c, pin_mux_pkg::OFF_OD_CLEAR), 32'hFFFF_FFFF);
			rd(ad(c, pin_mux_pkg::OFF_OD_STATUS), 32'h0000_0000);
			rd(ad(c, 8'h0C), 32'h0000_0000);
		end
	endtask

	task automatic s_own();
		for (int c = 0; c < 2; c++) begin
			wr(ad(c, pin_mux_pkg::OFF_OWN_CLEAR), 32'hFFFF_FFFF);
			rd(ad(c, pin_mux_pkg::OFF_OWN_STATUS), c ? 32'h0001_FFF8 : 32'h0000_0000);
			wr(ad(c, pin_mux_pkg::OFF_OWN_SET), 32'h0010_0000);
			rd(ad(c, pin_mux_pkg::OFF_OWN_STATUS), c ? 32'h0011_FFF8 : 32'h0010_0000);
			wr(ad(c, pin_mux_pkg::OFF_OWN_SET), 32'hFFFF_FFFF);
			rd(ad(c, pin_mux_pkg::OFF_OWN_STATUS), impl(c));
		end
	endtask

	task automatic s_od_gpio();
		wr(ad(0, pin_mux_pkg::OFF_OUT_EN_SET), 32'h0000_0001);
		wr(ad(0, pin_mux_pkg::OFF_DATA_SET), 32'h0000_0001);
		settle(2);
		chk(32'({a_pin_oe[0], a_pin_out[0]}), 32'h0000_0003);
		wr(ad(0, pin_mux_pkg::OFF_OD_SET), 32'h0000_0001);
		settle(2);
		chk(32'(a_pin_oe[0]), 32'h0000_0000);
		@(posedge hclk);
		a_ext <= 30'h0000_0001;
		settle(4);
		rd(ad(0, pin_mux_pkg::OFF_PIN_STATUS), 32'h3FFF_FFFE);
		a_ext <= 30'h0000_0000;
		wr(ad(0, pin_mux_pkg::OFF_DATA_CLEAR), 32'h0000_0001);
		settle(2);
		chk(32'({a_pin_oe[0], a_pin_out[0]}), 32'h0000_0002);
		wr(ad(0, pin_mux_pkg::OFF_OD_CLEAR), 32'h0000_0001);
		wr(ad(0, pin_mux_pkg::OFF_OUT_EN_CLEAR), 32'h0000_0001);
	endtask

	task automatic s_periph();
		for (int c = 0; c < 2; c++) wr(ad(c, pin_mux_pkg::OFF_OWN_CLEAR), 32'hFFFF_FFFF);
		{a_periph_oe, a_periph_out, b_periph_oe, b_periph_out} <= '1;
		settle(2);
		chk(32'(a_pin_oe & a_pin_out), pin_mux_pkg::A_DRIVE);
		chk(32'(b_pin_oe & b_pin_out), pin_mux_pkg::B_DRIVE);
		for (int c = 0; c < 2; c++) wr(ad(c, pin_mux_pkg::OFF_OD_SET), 32'hFFFF_FFFF);
		settle(2);
		chk(32'(a_pin_oe) | 32'(b_pin_oe), 32'h0000_0000);
		@(posedge hclk);
		a_periph_out <= '0;
		settle(2);
		chk(32'(a_pin_oe), pin_mux_pkg::A_DRIVE);
		chk(32'(a_pin_out), 32'h0000_0000);
		@(posedge hclk);
		{a_periph_oe, b_periph_oe} <= '0;
		a_ext <= 30'h2AAA_AAAA;
		b_ext <= 28'h555_5555;
		settle(4);
		chk(32'(a_periph_in), 32'h1555_5555 & pin_mux_pkg::A_RECV);
		chk(32'(b_periph_in), 32'h0AAA_AAAA & pin_mux_pkg::B_RECV);
		for (int c = 0; c < 2; c++) wr(ad(c, pin_mux_pkg::OFF_OWN_SET), 32'hFFFF_FFFF);
		settle(4);
		chk(32'(a_periph_in) | 32'(b_periph_in), 32'h0000_0000);
	endtask

	// reset for 8 cycles, then every scenario in turn
	initial begin
		hclk = 1'b0;
		hresetn = 1'b0;
		{hsel, hwrite, htrans, haddr, hwdata} = '0;
		hsize = 3'b010;
		{a_periph_out, a_periph_oe, a_ext, b_periph_out, b_periph_oe, b_ext} = '0;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		s_reset();
		s_od_regs();
		s_own();
		s_od_gpio();
		s_periph();
		conclude();
	end
endmodule // tb
`default_nettype wire
